// ===== common/fcseq_pkg.sv
// Package for the flash command sequencer: register offsets, bit positions,
// reset values, command codes, operation lengths, states and bus carriers.
// Assumes a 32-bit APB register bus and a 16-bit CPU port into the flash area.
package fcseq_pkg;

  // Register byte offsets on APB
  localparam logic [11:0] MAIN_OFS = 12'h220;
  localparam logic [11:0] AUX_OFS = 12'h224;
  localparam logic [11:0] POWER_OFS = 12'h228;
  localparam logic [11:0] MODE_OFS = 12'h230;

  // flash_main_control_reg bits
  localparam int READY_BIT = 0;
  localparam int CRE_BIT = 1;
  localparam int PERR_BIT = 6;
  localparam int EERR_BIT = 7;
  // flash_aux_control_reg bits
  localparam int MWE_BIT = 1;
  localparam int LSR_BIT = 6;
  localparam int DFW_BIT = 7;
  // flash_read_power_reg bits
  localparam int SLOW_BIT = 2;
  localparam int LOWC_BIT = 3;
  // rewrite_mode_select_reg bits
  localparam int RMS_BIT = 0;
  localparam int USE_BIT = 1;
  localparam int RSV5_BIT = 5;
  // Status byte bits
  localparam int SR_PROG_BIT = 4;
  localparam int SR_ERASE_BIT = 5;
  localparam int SR_SEQ_BIT = 7;

  // Reset values
  localparam logic RST_CRE = 1'b0;
  localparam logic RST_MWE = 1'b0;
  localparam logic RST_DFW = 1'b0;
  localparam logic RST_RMS = 1'b0;
  localparam logic RST_USE = 1'b0;
  localparam logic RST_LOCK = 1'b1;
  localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;

  // Command codes (low byte of the written word)
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM = 8'h41;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_LOCK_PROG = 8'h77;
  localparam logic [7:0] CMD_LOCK_READ = 8'h71;
  localparam logic [7:0] CMD_BLANK = 8'h25;
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;

  // Auto operation lengths in pclk cycles
  localparam logic [15:0] PROG_CYC = 16'h0010;
  localparam logic [15:0] ERASE_CYC = 16'h0040;
  localparam logic [15:0] LOCK_CYC = 16'h0008;
  localparam logic [15:0] CHECK_CYC = 16'h0008;

  // Read and write access lengths on the flash port
  localparam logic [1:0] RD_CYC = 2'h1;
  localparam logic [1:0] WR_CYC = 2'h0;

  typedef enum logic [1:0] {CS_IDLE, CS_D0, CS_PLO, CS_PHI} fcseq_cmd_t;
  typedef enum logic [1:0] {RM_ARRAY, RM_ONCE, RM_STAT} fcseq_rd_t;
  typedef enum logic [2:0] {OP_PROG, OP_ERASE, OP_LOCKP, OP_LOCKR, OP_BLANK} fcseq_op_t;

  typedef struct packed {
    logic sel;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } fcseq_fl_req_t;

  typedef struct packed {
    logic ready;
    logic [15:0] rdata;
  } fcseq_fl_rsp_t;

endpackage : fcseq_pkg

// ===== core/fcseq_core.sv
// Flash command sequencer: APB control registers, command decoder, auto
// program/erase engine and a small flip-flop flash array.
// Assumes the CPU flash port holds each request until fl_rsp.ready.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

module fcseq_core #(
  parameter int WORDS = 64,
  parameter int BLK_WORDS = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fcseq_pkg::fcseq_fl_req_t fl_req,
  output var fcseq_pkg::fcseq_fl_rsp_t fl_rsp,
  input wire logic bus_wait_state_bit,
  output logic rom_rewrite_mode,
  output logic slow_read_enable,
  output logic low_current_read_enable
);
  localparam int NBLK = WORDS / BLK_WORDS;
  localparam int IW = $clog2(WORDS);
  localparam int BW = $clog2(NBLK);

  logic [31:0] mem_reg [WORDS];
  logic [31:0] mem_next [WORDS];
  logic [NBLK-1:0] lock_reg, lock_next;
  logic cre_reg, cre_next, perr_reg, perr_next, eerr_reg, eerr_next;
  logic mwe_reg, mwe_next, lsr_reg, lsr_next, dfw_reg, dfw_next;
  logic slow_reg, slow_next, lowc_reg, lowc_next;
  logic rms_reg, rms_next, use_reg, use_next, rsv5_reg, rsv5_next;
  fcseq_pkg::fcseq_cmd_t cmd_reg, cmd_next;
  fcseq_pkg::fcseq_rd_t rmode_reg, rmode_next;
  fcseq_pkg::fcseq_op_t pend_reg, pend_next, op_reg, op_next;
  logic busy_reg, busy_next;
  logic [15:0] opcnt_reg, opcnt_next;
  logic [IW-1:0] waddr_reg, waddr_next, oaddr_reg, oaddr_next;
  logic [15:0] wlow_reg, wlow_next;
  logic [31:0] odata_reg, odata_next;
  logic [1:0] fcnt_reg, fcnt_next;
  logic [15:0] frdata_reg, frdata_next;
  logic [31:0] prdata_reg, prdata_next;

  logic [WORDS-1:0] word_blank;
  logic [NBLK-1:0] blk_blank;
  logic [IW-1:0] widx;
  logic [BW-1:0] oblk;
  logic [7:0] code, status;
  logic [1:0] need;
  logic hold, fready, fire, wr_cmd, errs, apb_hit;
  logic [31:0] apb_rd;

  genvar g;
  generate
    for (g = 0; g < WORDS; g++) begin : g_word
      assign word_blank[g] = &mem_reg[g];
    end
    for (g = 0; g < NBLK; g++) begin : g_blk
      assign blk_blank[g] = &word_blank[g*BLK_WORDS +: BLK_WORDS];
    end
  endgenerate

  assign widx = fl_req.addr[IW+1:2];
  assign oblk = oaddr_reg[IW-1:IW-BW];
  assign code = fl_req.wdata[7:0];
  assign errs = perr_reg | eerr_reg;
  assign status = {~busy_reg, 1'b0, eerr_reg, perr_reg, 4'h0};
  // Last block is data flash; only its reads take the extra wait
  assign need = fl_req.write ? fcseq_pkg::WR_CYC :
    2'(fcseq_pkg::RD_CYC + 2'((widx[IW-1:IW-BW] == BW'(NBLK-1)) & (~dfw_reg | bus_wait_state_bit)));
  // ROM-resident mode halts the CPU on the flash port while an operation runs
  assign hold = rms_reg & busy_reg;
  assign fready = fl_req.sel & ~hold & (fcnt_reg == need);
  assign fire = fready;
  assign wr_cmd = fire & fl_req.write & cre_reg & ~busy_reg;
  assign fl_rsp = '{ready: fready, rdata: frdata_reg};

  assign apb_hit = (paddr == fcseq_pkg::MAIN_OFS) | (paddr == fcseq_pkg::AUX_OFS) |
    (paddr == fcseq_pkg::POWER_OFS) | (paddr == fcseq_pkg::MODE_OFS);
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~apb_hit;
  assign prdata = prdata_reg;
  assign rom_rewrite_mode = rms_reg;
  assign slow_read_enable = slow_reg;
  assign low_current_read_enable = lowc_reg;

  always_comb begin
    apb_rd = 32'h00000000;
    unique case (paddr)
      fcseq_pkg::MAIN_OFS: begin
        apb_rd[fcseq_pkg::READY_BIT] = ~busy_reg;
        apb_rd[fcseq_pkg::CRE_BIT] = cre_reg;
        apb_rd[fcseq_pkg::PERR_BIT] = perr_reg;
        apb_rd[fcseq_pkg::EERR_BIT] = eerr_reg;
      end
      fcseq_pkg::AUX_OFS: begin
        apb_rd[fcseq_pkg::MWE_BIT] = mwe_reg;
        apb_rd[fcseq_pkg::LSR_BIT] = lsr_reg;
        apb_rd[fcseq_pkg::DFW_BIT] = dfw_reg;
      end
      fcseq_pkg::POWER_OFS: begin
        apb_rd[fcseq_pkg::SLOW_BIT] = slow_reg;
        apb_rd[fcseq_pkg::LOWC_BIT] = lowc_reg;
      end
      fcseq_pkg::MODE_OFS: begin
        apb_rd[fcseq_pkg::RMS_BIT] = rms_reg;
        apb_rd[fcseq_pkg::USE_BIT] = use_reg;
        apb_rd[fcseq_pkg::RSV5_BIT] = rsv5_reg;
      end
      default: apb_rd = 32'h00000000;
    endcase
  end

  always_comb begin
    mem_next = mem_reg;
    lock_next = lock_reg;
    cre_next = cre_reg;
    perr_next = perr_reg;
    eerr_next = eerr_reg;
    mwe_next = mwe_reg;
    lsr_next = lsr_reg;
    dfw_next = dfw_reg;
    slow_next = slow_reg;
    lowc_next = lowc_reg;
    rms_next = rms_reg;
    use_next = use_reg;
    rsv5_next = rsv5_reg;
    cmd_next = cmd_reg;
    rmode_next = rmode_reg;
    pend_next = pend_reg;
    op_next = op_reg;
    busy_next = busy_reg;
    opcnt_next = opcnt_reg;
    waddr_next = waddr_reg;
    oaddr_next = oaddr_reg;
    wlow_next = wlow_reg;
    odata_next = odata_reg;
    prdata_next = prdata_reg;

    // APB: read data captured in setup, writes land in the access phase
    if (psel && !penable && !pwrite) begin
      prdata_next = apb_rd;
    end
    if (psel && penable && pwrite) begin
      unique case (paddr)
        fcseq_pkg::MAIN_OFS: cre_next = pwdata[fcseq_pkg::CRE_BIT];
        fcseq_pkg::AUX_OFS: begin
          mwe_next = pwdata[fcseq_pkg::MWE_BIT];
          dfw_next = pwdata[fcseq_pkg::DFW_BIT];
        end
        fcseq_pkg::POWER_OFS: begin
          slow_next = pwdata[fcseq_pkg::SLOW_BIT];
          lowc_next = pwdata[fcseq_pkg::LOWC_BIT];
        end
        fcseq_pkg::MODE_OFS: begin
          use_next = pwdata[fcseq_pkg::USE_BIT];
          rsv5_next = pwdata[fcseq_pkg::RSV5_BIT];
          if (!pwdata[fcseq_pkg::RMS_BIT] || (cre_reg && mwe_reg)) begin
            rms_next = pwdata[fcseq_pkg::RMS_BIT];
          end
        end
        default: ;
      endcase
    end

    // One-shot status read falls back to array after being taken
    if (fire && !fl_req.write && rmode_reg == fcseq_pkg::RM_ONCE) begin
      rmode_next = fcseq_pkg::RM_ARRAY;
    end

    if (wr_cmd) begin
      unique case (cmd_reg)
        fcseq_pkg::CS_IDLE: begin
          unique case (code)
            fcseq_pkg::CMD_READ_ARRAY: rmode_next = fcseq_pkg::RM_ARRAY;
            fcseq_pkg::CMD_READ_STATUS: if (rmode_reg != fcseq_pkg::RM_STAT) rmode_next = fcseq_pkg::RM_ONCE;
            fcseq_pkg::CMD_CLEAR_STATUS: begin
              perr_next = 1'b0;
              eerr_next = 1'b0;
            end
            fcseq_pkg::CMD_PROGRAM: begin
              if (!errs) begin
                cmd_next = fcseq_pkg::CS_PLO;
                waddr_next = widx;
              end
            end
            fcseq_pkg::CMD_ERASE, fcseq_pkg::CMD_LOCK_PROG,
            fcseq_pkg::CMD_LOCK_READ, fcseq_pkg::CMD_BLANK: begin
              if (code == fcseq_pkg::CMD_LOCK_READ) begin
                rmode_next = fcseq_pkg::RM_ARRAY;
              end
              if (!errs) begin
                cmd_next = fcseq_pkg::CS_D0;
                pend_next = (code == fcseq_pkg::CMD_ERASE) ? fcseq_pkg::OP_ERASE :
                  (code == fcseq_pkg::CMD_LOCK_PROG) ? fcseq_pkg::OP_LOCKP :
                  (code == fcseq_pkg::CMD_LOCK_READ) ? fcseq_pkg::OP_LOCKR : fcseq_pkg::OP_BLANK;
              end
            end
            default: ;
          endcase
        end
        fcseq_pkg::CS_D0: begin
          cmd_next = fcseq_pkg::CS_IDLE;
          if (code == fcseq_pkg::CMD_CONFIRM) begin
            busy_next = 1'b1;
            op_next = pend_reg;
            oaddr_next = widx;
            opcnt_next = (pend_reg == fcseq_pkg::OP_ERASE) ? fcseq_pkg::ERASE_CYC :
              (pend_reg == fcseq_pkg::OP_BLANK) ? fcseq_pkg::CHECK_CYC : fcseq_pkg::LOCK_CYC;
            if (!rms_reg && pend_reg != fcseq_pkg::OP_LOCKR) begin
              rmode_next = fcseq_pkg::RM_STAT;
            end
          end
        end
        fcseq_pkg::CS_PLO: begin
          wlow_next = fl_req.wdata;
          cmd_next = fcseq_pkg::CS_PHI;
        end
        fcseq_pkg::CS_PHI: begin
          cmd_next = fcseq_pkg::CS_IDLE;
          busy_next = 1'b1;
          op_next = fcseq_pkg::OP_PROG;
          oaddr_next = waddr_reg;
          odata_next = {fl_req.wdata, wlow_reg};
          opcnt_next = fcseq_pkg::PROG_CYC;
          if (!rms_reg) begin
            rmode_next = fcseq_pkg::RM_STAT;
          end
        end
      endcase
    end

    if (busy_reg) begin
      opcnt_next = opcnt_reg - 16'h0001;
      if (opcnt_reg == 16'h0001) begin
        busy_next = 1'b0;
        unique case (op_reg)
          fcseq_pkg::OP_PROG: begin
            // Only an erased, unlocked word takes new data
            if (!lock_reg[oblk] || !word_blank[oaddr_reg]) begin
              perr_next = 1'b1;
            end else begin
              mem_next[oaddr_reg] = odata_reg;
            end
          end
          fcseq_pkg::OP_ERASE: begin
            if (!lock_reg[oblk]) begin
              eerr_next = 1'b1;
            end else begin
              for (int i = 0; i < WORDS; i++) begin
                if (i / BLK_WORDS == int'(oblk)) begin
                  mem_next[i] = fcseq_pkg::ERASED_WORD;
                end
              end
              lock_next[oblk] = 1'b1;
            end
          end
          fcseq_pkg::OP_LOCKP: lock_next[oblk] = 1'b0;
          fcseq_pkg::OP_LOCKR: lsr_next = lock_reg[oblk];
          fcseq_pkg::OP_BLANK: eerr_next = ~lock_reg[oblk] | ~blk_blank[oblk];
          default: ;
        endcase
      end
    end
  end

  // Flash port: count access cycles, load read data every read cycle
  always_comb begin
    fcnt_next = fcnt_reg;
    frdata_next = frdata_reg;
    if (!fl_req.sel || fready) begin
      fcnt_next = 2'h0;
    end else if (fcnt_reg != need) begin
      fcnt_next = fcnt_reg + 2'h1;
    end
    if (fl_req.sel && !fl_req.write) begin
      if (rmode_reg != fcseq_pkg::RM_ARRAY) begin
        frdata_next = {8'h00, status};
      end else begin
        frdata_next = fl_req.addr[1] ? mem_reg[widx][31:16] : mem_reg[widx][15:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_reg[i] <= fcseq_pkg::ERASED_WORD;
      end
      lock_reg <= {NBLK{fcseq_pkg::RST_LOCK}};
      cre_reg <= fcseq_pkg::RST_CRE;
      perr_reg <= 1'b0;
      eerr_reg <= 1'b0;
      mwe_reg <= fcseq_pkg::RST_MWE;
      lsr_reg <= 1'b0;
      dfw_reg <= fcseq_pkg::RST_DFW;
      slow_reg <= 1'b0;
      lowc_reg <= 1'b0;
      rms_reg <= fcseq_pkg::RST_RMS;
      use_reg <= fcseq_pkg::RST_USE;
      rsv5_reg <= 1'b0;
      cmd_reg <= fcseq_pkg::CS_IDLE;
      rmode_reg <= fcseq_pkg::RM_ARRAY;
      pend_reg <= fcseq_pkg::OP_ERASE;
      op_reg <= fcseq_pkg::OP_PROG;
      busy_reg <= 1'b0;
      opcnt_reg <= 16'h0000;
      waddr_reg <= '0;
      oaddr_reg <= '0;
      wlow_reg <= 16'h0000;
      odata_reg <= 32'h00000000;
      fcnt_reg <= 2'h0;
      frdata_reg <= 16'h0000;
      prdata_reg <= 32'h00000000;
    end else begin
      mem_reg <= mem_next;
      lock_reg <= lock_next;
      cre_reg <= cre_next;
      perr_reg <= perr_next;
      eerr_reg <= eerr_next;
      mwe_reg <= mwe_next;
      lsr_reg <= lsr_next;
      dfw_reg <= dfw_next;
      slow_reg <= slow_next;
      lowc_reg <= lowc_next;
      rms_reg <= rms_next;
      use_reg <= use_next;
      rsv5_reg <= rsv5_next;
      cmd_reg <= cmd_next;
      rmode_reg <= rmode_next;
      pend_reg <= pend_next;
      op_reg <= op_next;
      busy_reg <= busy_next;
      opcnt_reg <= opcnt_next;
      waddr_reg <= waddr_next;
      oaddr_reg <= oaddr_next;
      wlow_reg <= wlow_next;
      odata_reg <= odata_next;
      fcnt_reg <= fcnt_next;
      frdata_reg <= frdata_next;
      prdata_reg <= prdata_next;
    end
  end

endmodule : fcseq_core

`default_nettype wire

// ===== verification/fcseq_monitor.sv
// Assertion checker for the flash command sequencer, bound to fcseq_core.
// Assumes flash requests hold until acknowledged and idle a cycle between accesses.
`timescale 1ns/1ps
`default_nettype none
module fcseq_monitor #(
  parameter int WORDS = 64,
  parameter int BLK_WORDS = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire fcseq_pkg::fcseq_fl_req_t fl_req,
  input wire fcseq_pkg::fcseq_fl_rsp_t fl_rsp,
  input wire logic bus_wait_state_bit,
  input wire logic rom_rewrite_mode,
  input wire logic slow_read_enable,
  input wire logic low_current_read_enable
);
  logic cre_q, mwe_q, dfw_q, stat_q, apb_wr, mode_wr, aux_wr, df, rdq;
  assign apb_wr = psel && penable && pwrite;
  assign mode_wr = apb_wr && paddr == fcseq_pkg::MODE_OFS;
  assign aux_wr = apb_wr && paddr == fcseq_pkg::AUX_OFS;
  // Word index wraps at the array size, as the sequencer decodes it
  assign df = int'(fl_req.addr[15:2]) % WORDS >= WORDS - BLK_WORDS;
  assign rdq = fl_req.sel && !fl_req.write && !rom_rewrite_mode;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cre_q <= 1'h0;
      mwe_q <= 1'h0;
      dfw_q <= 1'h0;
      stat_q <= 1'h0;
    end else begin
      if (apb_wr && paddr == fcseq_pkg::MAIN_OFS) cre_q <= pwdata[fcseq_pkg::CRE_BIT];
      if (aux_wr) mwe_q <= pwdata[fcseq_pkg::MWE_BIT];
      if (aux_wr) dfw_q <= pwdata[fcseq_pkg::DFW_BIT];
      // Only valid while idle; the bench never issues this command when busy
      if (fl_req.sel && fl_rsp.ready) stat_q <= fl_req.write && cre_q &&
        fl_req.wdata[7:0] == fcseq_pkg::CMD_READ_STATUS;
    end
  end
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_rom_gate: assert property (mode_wr && pwdata[0] && !(cre_q && mwe_q) && !rom_rewrite_mode
    |=> !rom_rewrite_mode) else $error("mode select set without both enables");
  chk_rom_set: assert property (mode_wr && pwdata[0] && cre_q && mwe_q |=> rom_rewrite_mode)
    else $error("mode select not taken");
  chk_rom_clear: assert property (mode_wr && !pwdata[0] |=> !rom_rewrite_mode)
    else $error("mode select not cleared");
  chk_wr_ack: assert property (fl_req.sel && fl_req.write && !rom_rewrite_mode |-> fl_rsp.ready)
    else $error("flash write not acknowledged at once");
  chk_pf_read: assert property ($rose(fl_req.sel) && rdq && !df |-> !fl_rsp.ready ##1 fl_rsp.ready)
    else $error("program area read latency wrong");
  chk_df_wait: assert property ($rose(fl_req.sel) && rdq && df && !dfw_q
    |-> !fl_rsp.ready [*2] ##1 fl_rsp.ready) else $error("data flash read lacks its wait");
  chk_df_nowait: assert property ($rose(fl_req.sel) && rdq && df && dfw_q && !bus_wait_state_bit
    |-> !fl_rsp.ready ##1 fl_rsp.ready) else $error("data flash read waited needlessly");
  chk_status_byte: assert property (rdq && fl_rsp.ready && stat_q
    |=> fl_rsp.rdata[15:8] == 8'h00 && fl_rsp.rdata[7]) else $error("status byte not returned");
endmodule : fcseq_monitor
bind fcseq_core fcseq_monitor #(.WORDS(WORDS), .BLK_WORDS(BLK_WORDS)) i_fcseq_monitor (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fl_req, .fl_rsp,
  .bus_wait_state_bit, .rom_rewrite_mode, .slow_read_enable, .low_current_read_enable);
`default_nettype wire

// ===== verification/fcseq_cpu.sv
// CPU core model: 16-bit even-address flash reads, writes and command sequences.
// Assumes the sequencer answers every access with fl_rsp.ready.
`timescale 1ns/1ps
`default_nettype none
module fcseq_cpu (
  input wire logic pclk,
  output var fcseq_pkg::fcseq_fl_req_t fl_req,
  input wire fcseq_pkg::fcseq_fl_rsp_t fl_rsp
);
  initial fl_req = '0;
  // Returns the number of edges up to and including the acknowledge
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d, output int n);
    n = 0;
    @(posedge pclk);
    fl_req <= '{1'h1, w, {a[15:1], 1'h0}, d};
    do begin
      @(posedge pclk);
      n++;
    end while (fl_rsp.ready !== 1'h1);
    // Released lines carry inverted junk so nothing stale looks valid
    fl_req <= '{1'h0, !w, ~a, ~d};
  endtask : xfer
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    int n;
    xfer(1'h1, a, d, n);
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output int n);
    xfer(1'h0, a, 16'h0, n);
    d = fl_rsp.rdata;
  endtask : rd
  // Upper command byte is junk on purpose; only the low byte may count
  task automatic prog(input logic [15:0] a, input logic [31:0] d);
    wr({a[15:2], 2'h0}, 16'hA541);
    wr({a[15:2], 2'h0}, d[15:0]);
    wr({a[15:2], 2'h0}, d[31:16]);
  endtask : prog
  task automatic blk(input logic [7:0] c, input logic [15:0] top);
    wr(top, {8'h5A, c});
    wr(top, 16'h00D0);
  endtask : blk
endmodule : fcseq_cpu
`default_nettype wire

// ===== verification/tb_top.sv
// Testbench: APB register access and CPU flash traffic against the sequencer.
// Assumes the default array: four 64-byte blocks, the last one data flash.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [11:0] MN = fcseq_pkg::MAIN_OFS;
  localparam logic [11:0] AX = fcseq_pkg::AUX_OFS;
  localparam logic [11:0] MD = fcseq_pkg::MODE_OFS;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bws, rom, slow, lowc, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] fd;
  fcseq_pkg::fcseq_fl_req_t fl_req;
  fcseq_pkg::fcseq_fl_rsp_t fl_rsp;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  fcseq_core i_fcseq_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fl_req, .fl_rsp, .bus_wait_state_bit(bws), .rom_rewrite_mode(rom),
    .slow_read_enable(slow), .low_current_read_enable(lowc));
  fcseq_cpu i_fcseq_cpu (.pclk, .fl_req, .fl_rsp);
  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end
  task automatic end_sim;
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      $display("[FAIL] %0t timeout", $time);
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'h0, a, 32'h0);
    chk(rd & m, exp);
  endtask : rchk
  // Poll the ready flag; the global cycle limit bounds the wait
  task automatic idle;
    do apb(1'h0, MN, 32'h0); while (rd[0] !== 1'h1);
  endtask : idle
  task automatic fw(input logic [15:0] a, input logic [15:0] d);
    i_fcseq_cpu.wr(a, d);
  endtask : fw
  task automatic fr(input logic [15:0] a, input logic [15:0] exp);
    i_fcseq_cpu.rd(a, fd, n);
    chk({16'h0, fd}, {16'h0, exp});
  endtask : fr
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    bws = 1'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    rchk(MN, 32'h1, 32'hC3);
    rchk(AX, 32'h0, 32'h82);
    rchk(MD, 32'h0, 32'h23);
    rchk(12'h100, 32'h0, 32'hFFFFFFFF);
    chk({31'h0, err}, 32'h1);
    i_fcseq_cpu.prog(16'h10, 32'h12345678);
    rchk(MN, 32'h1, 32'h1);
    fr(16'h10, 16'hFFFF);
    apb(1'h1, MN, 32'h0);
    apb(1'h1, MN, 32'h2);
    i_fcseq_cpu.prog(16'h10, 32'h12345678);
    rchk(MN, 32'h0, 32'h1);
    idle();
    rchk(MN, 32'h1, 32'hC1);
    fr(16'h10, 16'h0080);
    fw(16'h0, 16'h00FF);
    fr(16'h10, 16'h5678);
    fr(16'h12, 16'h1234);
    i_fcseq_cpu.prog(16'h10, 32'h0);
    idle();
    rchk(MN, 32'h41, 32'hC1);
    fw(16'h0, 16'h00FF);
    fr(16'h10, 16'h5678);
    i_fcseq_cpu.blk(8'h20, 16'h3E);
    rchk(MN, 32'h41, 32'hC1);
    fr(16'h10, 16'h5678);
    fw(16'h0, 16'h0050);
    rchk(MN, 32'h1, 32'hC1);
    fw(16'h0, 16'h0070);
    fr(16'h10, 16'h0080);
    fr(16'h10, 16'h5678);
    i_fcseq_cpu.blk(8'h20, 16'h3E);
    idle();
    rchk(MN, 32'h1, 32'hC1);
    fw(16'h0, 16'h0050);
    fw(16'h0, 16'h0070);
    fr(16'h10, 16'h0080);
    fr(16'h10, 16'h0080);
    i_fcseq_cpu.blk(8'h71, 16'h3E);
    idle();
    rchk(AX, 32'h40, 32'h40);
    fr(16'h10, 16'hFFFF);
    i_fcseq_cpu.blk(8'h77, 16'h3E);
    idle();
    i_fcseq_cpu.blk(8'h71, 16'h3E);
    idle();
    rchk(AX, 32'h0, 32'h40);
    i_fcseq_cpu.prog(16'h20, 32'h0);
    idle();
    rchk(MN, 32'h41, 32'hC1);
    fw(16'h0, 16'h0050);
    i_fcseq_cpu.blk(8'h25, 16'h7E);
    idle();
    rchk(MN, 32'h1, 32'hC1);
    i_fcseq_cpu.blk(8'h25, 16'h3E);
    idle();
    rchk(MN, 32'h81, 32'hC1);
    fw(16'h0, 16'h0050);
    i_fcseq_cpu.blk(8'h20, 16'h3E);
    idle();
    rchk(MN, 32'h81, 32'hC1);
    fw(16'h0, 16'h0050);
    fw(16'h0, 16'h00FF);
    for (int i = 0; i < 3; i++) begin
      apb(1'h1, AX, {24'h0, i[0] | i[1], 7'h0});
      bws <= i[1];
      i_fcseq_cpu.rd(16'hC0, fd, n);
      chk(32'(n), (i == 1) ? 32'h2 : 32'h3);
    end
    apb(1'h1, AX, 32'h0);
    i_fcseq_cpu.xfer(1'h1, 16'hC0, 16'h00FF, n);
    chk(32'(n), 32'h1);
    apb(1'h1, MD, 32'h3);
    rchk(MD, 32'h2, 32'h23);
    apb(1'h1, AX, 32'h2);
    apb(1'h1, MN, 32'h0);
    apb(1'h1, MD, 32'h3);
    rchk(MD, 32'h2, 32'h23);
    apb(1'h1, MN, 32'h2);
    apb(1'h1, MD, 32'h3);
    rchk(MD, 32'h3, 32'h23);
    chk({31'h0, rom}, 32'h1);
    apb(1'h1, MD, 32'h2);
    rchk(MD, 32'h2, 32'h23);
    chk({31'h0, rom}, 32'h0);
    apb(1'h1, fcseq_pkg::POWER_OFS, 32'hC);
    rchk(fcseq_pkg::POWER_OFS, 32'hC, 32'hFFFFFFFF);
    chk({31'h0, err}, 32'h0);
    chk({30'h0, lowc, slow}, 32'h3);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
